// ==== rtl/ctmw_defs.vh ====
// Constants for the CAN transceiver mode, wake and transmit guard block
`ifndef CTMW_DEFS_VH
`define CTMW_DEFS_VH

// Register word offsets on the bus (byte address bits 7:2)
`define CTMW_AW 6
`define CTMW_OFF_CTRL 6'h00
`define CTMW_OFF_STATUS 6'h01
`define CTMW_OFF_EVENT 6'h02
`define CTMW_OFF_CONFIG 6'h03

// Control register fields
`define CTMW_CTRL_FORCE_SB 0
`define CTMW_CTRL_LOG_EN 1
`define CTMW_CTRL_W 2
`define CTMW_CTRL_RST 2'h2

// Status register fields
`define CTMW_ST_STANDBY 0
`define CTMW_ST_WAKE 1
`define CTMW_ST_DOM_TO 2
`define CTMW_ST_THERMAL 3
`define CTMW_ST_TX_EN 4
`define CTMW_ST_RX 5
`define CTMW_ST_ARMED 6
`define CTMW_ST_EV_AVAIL 7
`define CTMW_ST_EV_FULL 8
`define CTMW_ST_W 9

// Event word layout: bit 8 is the valid flag on reads
`define CTMW_EV_W 8
`define CTMW_EV_VALID 8
`define CTMW_EV_WAKE 8'h01
`define CTMW_EV_DOM_TO 8'h02
`define CTMW_EV_THERMAL 8'h03
`define CTMW_EV_NORMAL 8'h04
`define CTMW_EV_STANDBY 8'h05

// Synchroniser reset level: open inputs read high
`define CTMW_PIN_IDLE 3'h7

// Default timer counts in 100 MHz cycles
`define CTMW_WAKE_FILT_DEF 500
`define CTMW_DOM_TO_DEF 100000

`endif

// ==== rtl/ctmw_top.v ====
// CAN transceiver digital control: modes, wake-up, transmit guards
//
// Behaviour
// - Standby select low picks normal mode, high picks standby mode.
// - Normal mode passes transmit bits to bus; receive low means dominant.
// - Standby disables normal transmitter and receiver; low-power receiver stays on.
// - In standby a dominant longer than wake filter time drives receive low.
// - Split bias output is enabled only in normal mode, floating in standby.
// - Unconditioned variant: dominant at standby entry wakes after the wake filter time, with no glitch.
// - Conditioned variant: ignore entry dominant, wake only after recessive first.
// - After wake-up stay in standby, echoing dominants, until select released.
// - Over-temperature switches off only the transmitter; reception continues.
// - Thermal transmitter-off is latched, cleared only when transmit input goes high.
// - Dominant time-out timer starts on every falling edge of transmit input.
// - Transmit input low beyond time-out disables transmitter, bus goes recessive.
// - Rising edge of transmit input resets timer and re-enables transmission.
// - Unconnected transmit or select input reads high: recessive and standby.
// - In normal mode transmit low drives dominant, high leaves bus recessive.
//
// Added by the designer: the address map and the Wishbone interface to the registers.

`include "ctmw_defs.vh"

// Event FIFO, flip-flop storage with valid/ready on both sides
module ctmw_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  // Level
  output wire full_o
);
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0] wr_ff;
  reg [AW-1:0] rd_ff;
  reg [AW:0] cnt_ff;
  wire push;
  wire pop;

  // Full and empty come from the occupancy count
  assign in_ready_o = (cnt_ff != DEPTH[AW:0]);
  assign out_valid_o = (cnt_ff != {(AW+1){1'b0}});
  assign full_o = ~in_ready_o;
  assign out_data_o = mem_ff[rd_ff];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // Storage write, no reset needed for data
  always @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data_i;
    end
  end

  // Pointers wrap at DEPTH so any depth up to 2**AW works
  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_ff <= {AW{1'b0}};
      rd_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ff + 1'b1;
      end
      if (push & ~pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop & ~push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule // ctmw_fifo

module ctmw_top #(
  parameter WAKE_FILT_CYC = `CTMW_WAKE_FILT_DEF,
  parameter DOM_TO_CYC = `CTMW_DOM_TO_DEF,
  parameter CNT_W = 20,
  parameter CONDITIONED_WAKE = 0,
  parameter EV_DEPTH = 16,
  parameter EV_AW = 4
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  // Protocol controller side pins
  input wire tx_data_i,
  input wire low_power_select_i,
  output wire rx_data_o,
  // Bus front end: comparators and drivers
  input wire bus_dominant_i,
  input wire lp_bus_dominant_i,
  input wire over_temp_i,
  output wire bus_drive_dominant_o,
  output wire normal_tx_en_o,
  output wire normal_rx_en_o,
  output wire lp_rx_en_o,
  output wire split_bias_out_o
);
  // Mode states, one-hot
  localparam ST_STANDBY = 2'b01;
  localparam ST_NORMAL = 2'b10;

  reg [2:0] tx_sync_ff;
  reg [2:0] sel_sync_ff;
  reg [2:0] dom_sync_ff;
  reg [2:0] lp_sync_ff;
  reg [2:0] ot_sync_ff;
  reg tx_ff;
  reg sel_ff;
  reg dom_ff;
  reg lp_ff;
  reg ot_ff;
  reg tx_prev_ff;
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg armed_ff;
  reg [CNT_W-1:0] wake_cnt_ff;
  reg wake_ff;
  reg [CNT_W-1:0] to_cnt_ff;
  reg to_run_ff;
  reg dom_to_ff;
  reg thermal_ff;
  reg rx_ff;
  reg drive_ff;
  reg [`CTMW_CTRL_W-1:0] ctrl_ff;
  reg ack_ff;
  reg [31:0] dat_ff;
  reg [4:0] ev_pend_ff;
  reg wake_q_ff;
  reg to_q_ff;
  reg th_q_ff;
  reg [`CTMW_EV_W-1:0] ev_word;
  reg [4:0] ev_take;
  wire standby;
  wire want_standby;
  wire tx_fall;
  wire tx_rise;
  wire tx_en;
  wire qual_dom;
  wire [5:0] adr;
  wire req;
  wire ev_pop;
  wire ev_in_ready;
  wire ev_out_valid;
  wire ev_full;
  wire [`CTMW_EV_W-1:0] ev_out;
  wire [`CTMW_ST_W-1:0] status;

  // Bus address decode shared by reads and writes
  function is_reg;
    input [5:0] a;
    input [5:0] off;
    begin
      is_reg = (a == off);
    end
  endfunction

  // Pin synchronisers; transmit and select reset to high so open inputs idle as high, front-end inputs reset low
  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_sync_ff <= `CTMW_PIN_IDLE;
      sel_sync_ff <= `CTMW_PIN_IDLE;
      dom_sync_ff <= 3'h0;
      lp_sync_ff <= 3'h0;
      ot_sync_ff <= 3'h0;
    end else begin
      tx_sync_ff <= {tx_sync_ff[1:0], tx_data_i};
      sel_sync_ff <= {sel_sync_ff[1:0], low_power_select_i};
      dom_sync_ff <= {dom_sync_ff[1:0], bus_dominant_i};
      lp_sync_ff <= {lp_sync_ff[1:0], lp_bus_dominant_i};
      ot_sync_ff <= {ot_sync_ff[1:0], over_temp_i};
    end
  end

  // Accept a change only when stages two and three agree
  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_ff <= 1'b1;
      sel_ff <= 1'b1;
      dom_ff <= 1'b0;
      lp_ff <= 1'b0;
      ot_ff <= 1'b0;
      tx_prev_ff <= 1'b1;
    end else begin
      if (tx_sync_ff[1] == tx_sync_ff[2]) tx_ff <= tx_sync_ff[2];
      if (sel_sync_ff[1] == sel_sync_ff[2]) sel_ff <= sel_sync_ff[2];
      if (dom_sync_ff[1] == dom_sync_ff[2]) dom_ff <= dom_sync_ff[2];
      if (lp_sync_ff[1] == lp_sync_ff[2]) lp_ff <= lp_sync_ff[2];
      if (ot_sync_ff[1] == ot_sync_ff[2]) ot_ff <= ot_sync_ff[2];
      tx_prev_ff <= tx_ff;
    end
  end

  assign tx_fall = tx_prev_ff & ~tx_ff;
  assign tx_rise = ~tx_prev_ff & tx_ff;

  // Mode selection; software can also hold the part in standby
  assign want_standby = sel_ff | ctrl_ff[`CTMW_CTRL_FORCE_SB];
  assign standby = state_ff[0];

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_STANDBY: begin
        if (~want_standby) nxt_state = ST_NORMAL;
      end
      ST_NORMAL: begin
        if (want_standby) nxt_state = ST_STANDBY;
      end
      default: nxt_state = ST_STANDBY;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_STANDBY;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Wake filter: count a low-power dominant while standing
  assign qual_dom = standby & armed_ff & lp_ff &
                    (wake_cnt_ff >= WAKE_FILT_CYC[CNT_W-1:0]);

  always @(posedge clk_i) begin
    if (rst_i) begin
      wake_cnt_ff <= {CNT_W{1'b0}};
      armed_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else if (~standby) begin
      wake_cnt_ff <= {CNT_W{1'b0}};
      wake_ff <= 1'b0;
      // Conditioned build disarms so an entry dominant is ignored
      armed_ff <= (CONDITIONED_WAKE == 0);
    end else begin
      if (~lp_ff) begin
        wake_cnt_ff <= {CNT_W{1'b0}};
        armed_ff <= 1'b1;
      end else if (wake_cnt_ff < WAKE_FILT_CYC[CNT_W-1:0]) begin
        wake_cnt_ff <= wake_cnt_ff + 1'b1;
      end
      // Wake stays reported until standby is left: select released and no software hold
      if (qual_dom) wake_ff <= 1'b1;
    end
  end

  // Dominant time-out: start on fall, clear on rise
  always @(posedge clk_i) begin
    if (rst_i) begin
      to_cnt_ff <= {CNT_W{1'b0}};
      to_run_ff <= 1'b0;
      dom_to_ff <= 1'b0;
    end else if (tx_rise | tx_ff) begin
      to_cnt_ff <= {CNT_W{1'b0}};
      to_run_ff <= 1'b0;
      dom_to_ff <= 1'b0;
    end else if (tx_fall) begin
      to_cnt_ff <= {CNT_W{1'b0}};
      to_run_ff <= 1'b1;
    end else if (to_run_ff) begin
      if (to_cnt_ff >= DOM_TO_CYC[CNT_W-1:0]) begin
        dom_to_ff <= 1'b1;
      end else begin
        to_cnt_ff <= to_cnt_ff + 1'b1;
      end
    end
  end

  // Thermal latch; a new trip wins over the tx-high clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      thermal_ff <= 1'b0;
    end else if (ot_ff) begin
      thermal_ff <= 1'b1;
    end else if (tx_ff) begin
      thermal_ff <= 1'b0;
    end
  end

  // Transmitter only runs in normal mode with no guard tripped
  assign tx_en = ~standby & ~dom_to_ff & ~thermal_ff;

  // Registered outputs toward bus driver and controller
  always @(posedge clk_i) begin
    if (rst_i) begin
      drive_ff <= 1'b0;
      rx_ff <= 1'b1;
    end else begin
      drive_ff <= tx_en & ~tx_ff;
      if (standby) begin
        rx_ff <= ~qual_dom;
      end else begin
        rx_ff <= ~dom_ff;
      end
    end
  end

  assign bus_drive_dominant_o = drive_ff;
  assign rx_data_o = rx_ff;
  assign normal_tx_en_o = tx_en;
  assign normal_rx_en_o = ~standby;
  assign lp_rx_en_o = standby;
  assign split_bias_out_o = ~standby;

  // Event capture: sticky pending bits, new edge wins over take
  always @(posedge clk_i) begin
    if (rst_i) begin
      ev_pend_ff <= 5'h00;
      wake_q_ff <= 1'b0;
      to_q_ff <= 1'b0;
      th_q_ff <= 1'b0;
    end else begin
      wake_q_ff <= wake_ff;
      to_q_ff <= dom_to_ff;
      th_q_ff <= thermal_ff;
      ev_pend_ff <= (ev_pend_ff & ~ev_take) |
        ({5{ctrl_ff[`CTMW_CTRL_LOG_EN]}} &
         {standby & (state_ff != nxt_state) ? 1'b0 : 1'b0,
          ~standby & (nxt_state == ST_STANDBY),
          th_q_ff ^ thermal_ff ? thermal_ff : 1'b0,
          dom_to_ff & ~to_q_ff,
          wake_ff & ~wake_q_ff}) |
        ({5{ctrl_ff[`CTMW_CTRL_LOG_EN]}} &
         {standby & (nxt_state == ST_NORMAL), 4'h0});
    end
  end

  // Pick one pending event per cycle; stalls while FIFO is full
  always @* begin
    ev_word = 8'h00;
    ev_take = 5'h00;
    if (ev_in_ready) begin
      if (ev_pend_ff[0]) begin
        ev_word = `CTMW_EV_WAKE;
        ev_take = 5'h01;
      end else if (ev_pend_ff[1]) begin
        ev_word = `CTMW_EV_DOM_TO;
        ev_take = 5'h02;
      end else if (ev_pend_ff[2]) begin
        ev_word = `CTMW_EV_THERMAL;
        ev_take = 5'h04;
      end else if (ev_pend_ff[3]) begin
        ev_word = `CTMW_EV_STANDBY;
        ev_take = 5'h08;
      end else if (ev_pend_ff[4]) begin
        ev_word = `CTMW_EV_NORMAL;
        ev_take = 5'h10;
      end
    end
  end

  ctmw_fifo #(
    .WIDTH(`CTMW_EV_W),
    .DEPTH(EV_DEPTH),
    .AW(EV_AW)
  ) u_ev_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(|ev_take),
    .in_ready_o(ev_in_ready),
    .in_data_i(ev_word),
    .out_valid_o(ev_out_valid),
    .out_ready_i(ev_pop),
    .out_data_o(ev_out),
    .full_o(ev_full)
  );

  // Status word
  assign status = {ev_full, ev_out_valid, armed_ff, rx_ff, tx_en,
                   thermal_ff, dom_to_ff, wake_ff, standby};

  // Wishbone classic: ack one cycle after request, dropped next cycle
  assign adr = wb_adr_i[7:2];
  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign ev_pop = req & ~wb_we_i & is_reg(adr, `CTMW_OFF_EVENT);

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
      ctrl_ff <= `CTMW_CTRL_RST;
    end else begin
      ack_ff <= req;
      if (req & wb_we_i) begin
        if (is_reg(adr, `CTMW_OFF_CTRL) & wb_sel_i[0]) begin
          ctrl_ff <= wb_dat_i[`CTMW_CTRL_W-1:0];
        end
      end
      // Unmapped reads return zero
      if (req & ~wb_we_i) begin
        if (is_reg(adr, `CTMW_OFF_CTRL)) begin
          dat_ff <= {{(32-`CTMW_CTRL_W){1'b0}}, ctrl_ff};
        end else if (is_reg(adr, `CTMW_OFF_STATUS)) begin
          dat_ff <= {{(32-`CTMW_ST_W){1'b0}}, status};
        end else if (is_reg(adr, `CTMW_OFF_EVENT)) begin
          dat_ff <= {23'h000000, ev_out_valid, ev_out};
        end else if (is_reg(adr, `CTMW_OFF_CONFIG)) begin
          dat_ff <= {31'h00000000, CONDITIONED_WAKE != 0};
        end else begin
          dat_ff <= 32'h0000_0000;
        end
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
endmodule // ctmw_top

// ==== tb/ctmw_top_properties.sv ====
// Pin-level assertions for the mode, wake and transmit guard block
module ctmw_top_properties #(
  parameter WAKE_FILT_CYC = 8,
  parameter DOM_TO_CYC = 40
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Controller side
  input wire tx_data_i,
  input wire low_power_select_i,
  input wire rx_data_o,
  // Front end
  input wire bus_dominant_i,
  input wire lp_bus_dominant_i,
  input wire over_temp_i,
  input wire bus_drive_dominant_o,
  input wire normal_tx_en_o,
  input wire normal_rx_en_o,
  input wire lp_rx_en_o,
  input wire split_bias_out_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] lp_cnt_ff;
  logic [15:0] txl_cnt_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Raw run lengths; the filtered view inside can only be shorter
  always @(posedge clk_i) begin
    if (rst_i || !lp_bus_dominant_i) lp_cnt_ff <= 16'h0000;
    else if (lp_cnt_ff != 16'hffff) lp_cnt_ff <= lp_cnt_ff + 16'h0001;
    if (rst_i || tx_data_i) txl_cnt_ff <= 16'h0000;
    else if (txl_cnt_ff != 16'hffff) txl_cnt_ff <= txl_cnt_ff + 16'h0001;
  end

  AST_RESET_STATE: assert property ($fell(rst_i) |-> lp_rx_en_o && rx_data_o
    && !normal_tx_en_o && !bus_drive_dominant_o) else $error("bad reset state");
  AST_ONE_MODE: assert property (normal_rx_en_o != lp_rx_en_o)
    else $error("modes overlap");
  AST_STANDBY_SEL: assert property (low_power_select_i [*8] |-> lp_rx_en_o)
    else $error("select high but not standby");
  AST_TX_NORMAL: assert property (normal_tx_en_o |-> normal_rx_en_o)
    else $error("transmitter on in standby");
  AST_SPLIT_NORMAL: assert property (split_bias_out_o |-> normal_rx_en_o)
    else $error("split bias outside normal mode");
  AST_RX_DOM: assert property ((normal_rx_en_o && bus_dominant_i) [*8]
    |-> !rx_data_o) else $error("receive not low on dominant");
  AST_RX_REC: assert property ((normal_rx_en_o && !bus_dominant_i) [*8]
    |-> rx_data_o) else $error("receive not high on recessive");
  AST_STBY_IDLE: assert property ((lp_rx_en_o && !lp_bus_dominant_i) [*8]
    |-> rx_data_o) else $error("wake shown without bus activity");
  // Only the start of a wake report is timed: the echo lags the bus release
  AST_WAKE_FILT: assert property ($fell(rx_data_o) && lp_rx_en_o
    && $past(lp_rx_en_o) |-> lp_cnt_ff >= WAKE_FILT_CYC)
    else $error("wake shown before filter time");
  AST_TX_DRIVE: assert property ((normal_tx_en_o && !tx_data_i) [*8]
    |-> bus_drive_dominant_o) else $error("transmit low not driven");
  AST_TX_REC: assert property (tx_data_i [*8] |-> !bus_drive_dominant_o)
    else $error("bus driven while transmit high");
  AST_DRIVE_GATED: assert property (bus_drive_dominant_o && !normal_tx_en_o
    |=> !bus_drive_dominant_o) else $error("drive outlives enable");
  AST_TIMEOUT: assert property (txl_cnt_ff > DOM_TO_CYC + 12
    |-> !bus_drive_dominant_o) else $error("dominant time-out missed");
  AST_THERMAL: assert property (over_temp_i [*8] |-> !normal_tx_en_o)
    else $error("transmitter on while hot");
endmodule // ctmw_top_properties

bind ctmw_top ctmw_top_properties #(.WAKE_FILT_CYC(WAKE_FILT_CYC),
  .DOM_TO_CYC(DOM_TO_CYC)) u_props (.clk_i, .rst_i, .tx_data_i,
  .low_power_select_i, .rx_data_o, .bus_dominant_i, .lp_bus_dominant_i,
  .over_temp_i, .bus_drive_dominant_o, .normal_tx_en_o, .normal_rx_en_o,
  .lp_rx_en_o, .split_bias_out_o);

// ==== tb/ctmw_ctrl_model.sv ====
// Protocol controller model driving transmit and standby select
module ctmw_ctrl_model #(
  parameter int BIT_CYC = 16
) (
  // Clock
  input wire logic clk_i,
  // Pins toward the transceiver
  output logic tx_data_o,
  output logic low_power_select_o,
  input wire logic rx_data_i
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle like an open pin: recessive and standby
  initial begin
    tx_data_o = 1'b1;
    low_power_select_o = 1'b1;
  end

  // Mode request
  task automatic set_mode(input logic stby);
    @(posedge clk_i);
    low_power_select_o <= stby;
  endtask

  // Hold one transmit level for n cycles
  task automatic drive_tx(input logic b, input int n);
    @(posedge clk_i);
    tx_data_o <= b;
    repeat (n - 1) @(posedge clk_i);
  endtask

  // Stuffing after two equal bits keeps runs to at most two bits, below the time-out
  task automatic send_bits(input logic [15:0] bits, output logic [15:0] seen,
    output logic [15:0] sent);
    int run;
    logic prev;
    logic b;
    run = 0;
    prev = 1'b1;
    for (int i = 0; i < 16; i++) begin
      b = (run == 2) ? ~prev : bits[i];
      run = (b == prev) ? run + 1 : 1;
      prev = b;
      sent[i] = b;
      drive_tx(b, BIT_CYC);
      seen[i] = rx_data_i;
    end
    drive_tx(1'b1, 4);
  endtask
endmodule // ctmw_ctrl_model

// ==== tb/ctmw_top_tb.sv ====
// Self-checking bench for the transceiver mode, wake and guard block
module ctmw_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WF = 8;
  localparam int DT = 40;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] bsel = 4'h0;
  logic drv2, lrx2, nrx2;
  logic [31:0] dat2;
  logic [31:0] wdat = 32'h0;
  logic lp_dom = 1'b0;
  logic hot = 1'b0;
  logic bus_short = 1'b0;
  logic tx, sel, rx, rx2, drv, tx_en, nrx_en, lrx_en, split, ack, bus_dom, s;
  logic [31:0] dat_o, rdat;
  logic [15:0] seen, sent;
  int bad_count = 0;
  int n_checks = 0;

  // Clock and a bus that reflects our own drive or a forced short
  always #5 clk_i = ~clk_i;
  assign bus_dom = drv | bus_short;

  // Unconditioned build under test, conditioned build beside it
  ctmw_top #(.WAKE_FILT_CYC(WF), .DOM_TO_CYC(DT)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(bsel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .tx_data_i(tx),
    .low_power_select_i(sel), .rx_data_o(rx), .bus_dominant_i(bus_dom),
    .lp_bus_dominant_i(lp_dom), .over_temp_i(hot),
    .bus_drive_dominant_o(drv), .normal_tx_en_o(tx_en),
    .normal_rx_en_o(nrx_en), .lp_rx_en_o(lrx_en), .split_bias_out_o(split));
  ctmw_top #(.WAKE_FILT_CYC(WF), .DOM_TO_CYC(DT), .CONDITIONED_WAKE(1)) uut_c (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(bsel), .wb_dat_i(wdat),
    .wb_dat_o(dat2), .wb_ack_o(), .tx_data_i(tx), .low_power_select_i(sel),
    .rx_data_o(rx2), .bus_dominant_i(bus_dom), .lp_bus_dominant_i(lp_dom),
    .over_temp_i(hot), .bus_drive_dominant_o(drv2), .normal_tx_en_o(),
    .normal_rx_en_o(nrx2), .lp_rx_en_o(lrx2), .split_bias_out_o());
  ctmw_ctrl_model #(.BIT_CYC(16)) ctrl (.clk_i(clk_i), .tx_data_o(tx),
    .low_power_select_o(sel), .rx_data_i(rx));

  // One comparison, counted
  task automatic check(input string what, input logic [31:0] seen_v,
    input logic [31:0] exp_v);
    n_checks++;
    if (seen_v !== exp_v) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp_v, seen_v);
    end
  endtask

  // Classic single Wishbone cycle; waits for ack, no fixed latency assumed
  task automatic wb_xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    bsel <= 4'hf;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dat_o;
    check("wishbone ack", 32'(ack), 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    bsel <= 4'h0;
  endtask

  // Expected {split, normal rx, low-power rx, tx enable} for a select level
  function automatic logic [3:0] mode_pins(input logic stby);
    return {~stby, ~stby, stby, ~stby};
  endfunction

  task automatic complete_run();
    $display("Counts: %0d checks, %0d mismatches", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #300000;
    bad_count++;
    complete_run();
  end

  // Test sequence
  initial begin
    void'($urandom(32'hc422a6e4));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("reset pins", 32'({split, nrx_en, lrx_en, tx_en, rx, drv}), 32'h0a);
    wb_xfer(1'b0, 8'h00, 32'h0, rdat);
    check("ctrl reset", rdat, 32'h2);
    wb_xfer(1'b0, 8'h0c, 32'h0, rdat);
    check("config", rdat, 32'h0);
    check("config conditioned", dat2, 32'h1);
    wb_xfer(1'b0, 8'h40, 32'h0, rdat);
    check("unmapped read", rdat, 32'h0);
    wb_xfer(1'b0, 8'h08, 32'h0, rdat);
    check("event empty", rdat, 32'h0);
    $display("Test reset done");

    ctrl.set_mode(1'b0);
    repeat (10) @(posedge clk_i);
    check("normal pins", 32'({split, nrx_en, lrx_en, tx_en}), 32'(mode_pins(1'b0)));
    ctrl.send_bits(16'($urandom), seen, sent);
    check("rx loopback", 32'(seen), 32'(sent));
    wb_xfer(1'b0, 8'h08, 32'h0, rdat);
    check("normal entry event", rdat, 32'h104);
    $display("Test normal data done");

    ctrl.drive_tx(1'b0, 30);
    check("drive before timeout", 32'(drv), 32'h1);
    repeat (30) @(posedge clk_i);
    check("drive after timeout", 32'(drv), 32'h0);
    wb_xfer(1'b0, 8'h04, 32'h0, rdat);
    check("timeout status", 32'(rdat[2]), 32'h1);
    ctrl.drive_tx(1'b1, 10);
    check("tx re-enabled", 32'(tx_en), 32'h1);
    ctrl.drive_tx(1'b0, 30);
    check("timer restarted", 32'(drv), 32'h1);
    ctrl.drive_tx(1'b1, 10);
    $display("Test time-out done");

    hot <= 1'b1;
    bus_short <= 1'b1;
    ctrl.drive_tx(1'b0, 10);
    check("thermal tx off", 32'({tx_en, drv, drv2}), 32'h0);
    check("thermal rx alive", 32'(rx), 32'h0);
    hot <= 1'b0;
    bus_short <= 1'b0;
    ctrl.drive_tx(1'b0, 10);
    check("thermal latched", 32'(tx_en), 32'h0);
    ctrl.drive_tx(1'b1, 10);
    check("thermal cleared", 32'(tx_en), 32'h1);
    $display("Test thermal done");

    for (int i = 0; i < 6; i++) begin
      s = 1'($urandom);
      ctrl.set_mode(s);
      repeat (10) @(posedge clk_i);
      check("mode pins", 32'({split, nrx_en, lrx_en, tx_en}), 32'(mode_pins(s)));
    end
    $display("Test mode changes done");

    ctrl.set_mode(1'b0);
    lp_dom <= 1'b1;
    repeat (10) @(posedge clk_i);
    ctrl.set_mode(1'b1);
    repeat (7) @(posedge clk_i);
    check("entry glitch", 32'({rx, rx2}), 32'h3);
    repeat (WF + 8) @(posedge clk_i);
    check("entry wake", 32'({rx, rx2, lrx_en, lrx2}), 32'h7);
    lp_dom <= 1'b0;
    repeat (8) @(posedge clk_i);
    check("echo released", 32'({rx, rx2}), 32'h3);
    lp_dom <= 1'b1;
    repeat (4) @(posedge clk_i);
    check("short pulse", 32'({rx, rx2}), 32'h3);
    repeat (WF + 8) @(posedge clk_i);
    check("new wake", 32'({rx, rx2, lrx_en, lrx2}), 32'h3);
    wb_xfer(1'b0, 8'h04, 32'h0, rdat);
    check("wake status", 32'(rdat[1]), 32'h1);
    lp_dom <= 1'b0;
    ctrl.set_mode(1'b0);
    repeat (10) @(posedge clk_i);
    check("left standby", 32'({nrx_en, nrx2}), 32'h3);
    $display("Test wake done");

    // Software hold in standby, with event logging off, then release
    wb_xfer(1'b1, 8'h00, 32'h1, rdat);
    repeat (2) @(posedge clk_i);
    check("forced standby", 32'({lrx_en, lrx2, tx_en, split}), 32'hc);
    wb_xfer(1'b1, 8'h00, 32'h2, rdat);
    repeat (2) @(posedge clk_i);
    check("force released", 32'({nrx_en, nrx2, tx_en}), 32'h7);
    $display("Test forced standby done");
    complete_run();
  end
endmodule // ctmw_top_tb
